// ---- src/frr_regs.vh ----
// Register offsets, function codes, limits, CRC constants and timing counts of the result bank.
`ifndef FRR_REGS_VH
`define FRR_REGS_VH
`define FRR_FC_READ_HOLD     8'h03
`define FRR_FC_READ_INPUT    8'h04
`define FRR_FC_EXC_FUNC      8'h01
`define FRR_FC_EXC_ADDR      8'h02
`define FRR_FC_ERR_BIT       8'h80
`define FRR_ADDR_VELOCITY    16'h0001
`define FRR_ADDR_LEVEL       16'h0002
`define FRR_ADDR_AIR_GAP     16'h0003
`define FRR_ADDR_INST_FLOW   16'h0004
`define FRR_ADDR_VOL_HI      16'h0005
`define FRR_ADDR_VOL_MID     16'h0006
`define FRR_ADDR_VOL_LO      16'h0007
`define FRR_ADDR_VEL_SIGNAL  16'h0008
`define FRR_ADDR_LVL_SIGNAL  16'h0009
`define FRR_ADDR_DIRECTION   16'h000a
`define FRR_ADDR_IN_FAULT    16'h000b
`define FRR_ADDR_IN_TILT     16'h000c
`define FRR_ADDR_IN_SUPPLY   16'h000d
`define FRR_ADDR_IN_VERSION  16'h000e
`define FRR_ADDR_IN_LFLOW_HI 16'h000f
`define FRR_ADDR_IN_LFLOW_LO 16'h0010
`define FRR_ADDR_HOLD_FAULT  16'h0021
`define FRR_ADDR_HOLD_TILT   16'h0022
`define FRR_ADDR_HOLD_SUPPLY 16'h0023
`define FRR_DIR_REVERSE      16'h0000
`define FRR_DIR_FORWARD      16'h0001
`define FRR_SMALL_FLOW_MAX   32'h0000ffff
`define FRR_BYTE_COUNT_ONE   8'h02
`define FRR_MAX_QTY          16'h007d
`define FRR_CRC_INIT         16'hffff
`define FRR_CRC_POLY         16'ha001
`define FRR_CLK_HZ           125000000
`define FRR_SETTLE_STRONG_S  30
`define FRR_SETTLE_WEAK_S    120
`define FRR_SETTLE_STRONG_CYC (`FRR_SETTLE_STRONG_S * `FRR_CLK_HZ)
`define FRR_SETTLE_WEAK_CYC   (`FRR_SETTLE_WEAK_S * `FRR_CLK_HZ)
`define FRR_TICK_MS_CYC      (`FRR_CLK_HZ / 1000)
`endif

// ---- src/frr_result_bank.v ----
// Result register bank with request decoder, reply byte stream and sleep extrapolation.
`timescale 1ns/1ps
`default_nettype none
`include "frr_regs.vh"
module frr_result_bank #(
    parameter [15:0] FIRMWARE_VERSION = 16'h0100,
    parameter [31:0] SETTLE_CYC       = `FRR_SETTLE_STRONG_CYC,
    parameter [31:0] MS_TICK_CYC      = `FRR_TICK_MS_CYC
) (
    input  wire        i_sys_clk,
    input  wire        i_sys_rst,
    input  wire        i_req_valid,
    input  wire [7:0]  i_req_slave_addr,
    input  wire [7:0]  i_req_func,
    input  wire [15:0] i_req_start,
    input  wire [15:0] i_req_qty,
    input  wire        i_meas_valid,
    input  wire [15:0] i_meas_velocity,
    input  wire [15:0] i_meas_level,
    input  wire [15:0] i_meas_air_gap,
    input  wire [31:0] i_meas_flow,
    input  wire [15:0] i_meas_vel_signal,
    input  wire        i_meas_forward,
    input  wire [15:0] i_meas_fault,
    input  wire [15:0] i_meas_tilt,
    input  wire [15:0] i_meas_supply,
    input  wire [15:0] i_sleep_seconds,
    input  wire        i_sleep_request,
    input  wire        i_clear_volume,
    input  wire        i_tx_ready,
    output reg         o_req_ready,
    output reg         o_tx_valid,
    output reg  [7:0]  o_tx_byte,
    output reg         o_tx_last,
    output reg         o_meas_start,
    output reg         o_sleeping,
    output reg         o_settled
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_HEAD = 3'h1;
    localparam [2:0] ST_DATA = 3'h2;
    localparam [2:0] ST_CRC  = 3'h3;
    localparam [1:0] SL_AWAKE = 2'h0;
    localparam [1:0] SL_FRESH = 2'h1;
    localparam [1:0] SL_DOZE  = 2'h2;
    localparam [1:0] SL_WAKE  = 2'h3;

    reg  [15:0] velocity;
    reg  [15:0] level;
    reg  [15:0] air_gap;
    reg  [31:0] large_flow;
    reg  [47:0] volume;
    reg  [15:0] vel_signal;
    reg  [15:0] direction;
    reg  [15:0] fault;
    reg  [15:0] tilt;
    reg  [15:0] supply;
    reg  [15:0] small_flow;
    reg  [2:0]  state;
    reg  [1:0]  head_idx;
    reg  [7:0]  fc;
    reg  [7:0]  slave;
    reg  [15:0] addr;
    reg  [15:0] remain;
    reg         lo_byte;
    reg         err_reply;
    reg  [7:0]  err_code;
    reg  [15:0] crc;
    reg  [15:0] snap [0:35];
    reg  [1:0]  sl_state;
    reg  [15:0] sleep_len;
    reg  [15:0] sec_left;
    reg  [9:0]  ms_count;
    reg  [31:0] tick;
    reg  [31:0] settle_cnt;
    reg  [15:0] word;
    reg  [7:0]  next_byte;
    reg  [15:0] next_crc;
    reg         word_ok;
    wire        sending;
    integer     k;
    integer     j;

    assign sending = o_tx_valid && i_tx_ready;

    // Address decode over the frozen image; unmapped words flag an error.
    always @*
    begin
        word_ok = 1'b0;
        word    = 16'h0000;
        if (fc == `FRR_FC_READ_INPUT && addr >= `FRR_ADDR_VELOCITY &&
            addr <= `FRR_ADDR_IN_LFLOW_LO)
        begin
            word_ok = 1'b1;
            word    = snap[addr[5:0]];
        end
        else if (fc == `FRR_FC_READ_HOLD && ((addr >= `FRR_ADDR_VELOCITY &&
                 addr <= `FRR_ADDR_DIRECTION) || (addr >= `FRR_ADDR_HOLD_FAULT &&
                 addr <= `FRR_ADDR_HOLD_SUPPLY)))
        begin
            word_ok = 1'b1;
            word    = snap[addr[5:0]];
        end
    end

    // Byte about to be sent in the current state.
    always @*
    begin
        next_byte = 8'h00;
        case (state)
            ST_HEAD:
            begin
                case (head_idx)
                    2'h0:    next_byte = slave;
                    2'h1:    next_byte = err_reply ? (fc | `FRR_FC_ERR_BIT) : fc;
                    default: next_byte = err_reply ? err_code : remain[6:0] * 8'h02;
                endcase
            end
            ST_DATA: next_byte = lo_byte ? word[7:0] : word[15:8];
            ST_CRC:  next_byte = lo_byte ? crc[15:8] : crc[7:0];
            default: next_byte = 8'h00;
        endcase
    end

    always @*
    begin
        next_crc = crc ^ {8'h00, next_byte};
        for (k = 0; k < 8; k = k + 1)
        begin
            next_crc = next_crc[0] ? ((next_crc >> 1) ^ `FRR_CRC_POLY) : (next_crc >> 1);
        end
    end

    // Live measurement registers and sleep sequencing.
    always @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            velocity     <= 16'h0000;
            level        <= 16'h0000;
            air_gap      <= 16'h0000;
            large_flow   <= 32'h00000000;
            volume       <= 48'h000000000000;
            vel_signal   <= 16'h0000;
            direction    <= `FRR_DIR_REVERSE;
            fault        <= 16'h0000;
            tilt         <= 16'h0000;
            supply       <= 16'h0000;
            small_flow   <= 16'h0000;
            sl_state     <= SL_AWAKE;
            sleep_len    <= 16'h0000;
            sec_left     <= 16'h0000;
            ms_count     <= 10'h000;
            tick         <= 32'h00000000;
            settle_cnt   <= 32'h00000000;
            o_meas_start <= 1'b0;
            o_sleeping   <= 1'b0;
            o_settled    <= 1'b0;
        end
        else
        begin
            o_meas_start <= 1'b0;
            if (settle_cnt >= SETTLE_CYC)
            begin
                o_settled <= 1'b1;
            end
            else if (sl_state == SL_AWAKE)
            begin
                settle_cnt <= settle_cnt + 32'h00000001;
            end
            if (i_meas_valid && sl_state != SL_DOZE)
            begin
                velocity   <= i_meas_velocity;
                level      <= i_meas_level;
                air_gap    <= i_meas_air_gap;
                large_flow <= i_meas_flow;
                vel_signal <= i_meas_vel_signal;
                direction  <= i_meas_forward ? `FRR_DIR_FORWARD : `FRR_DIR_REVERSE;
                fault      <= i_meas_fault;
                tilt       <= i_meas_tilt;
                supply     <= i_meas_supply;
                small_flow <= (i_meas_flow > `FRR_SMALL_FLOW_MAX) ? 16'hffff
                                                                   : i_meas_flow[15:0];
            end
            if (i_clear_volume)
            begin
                volume <= 48'h000000000000;
            end
            case (sl_state)
                SL_AWAKE:
                begin
                    if (i_sleep_request && i_sleep_seconds != 16'h0000)
                    begin
                        sleep_len    <= i_sleep_seconds;
                        sl_state     <= SL_FRESH;
                        o_meas_start <= 1'b1;
                    end
                end
                SL_FRESH:
                begin
                    if (i_meas_valid)
                    begin
                        sl_state   <= SL_DOZE;
                        o_sleeping <= 1'b1;
                        sec_left   <= sleep_len;
                        ms_count   <= 10'h000;
                        tick       <= 32'h00000000;
                    end
                end
                SL_DOZE:
                begin
                    if (tick + 32'h00000001 >= MS_TICK_CYC)
                    begin
                        tick <= 32'h00000000;
                        if (ms_count == 10'h3e7)
                        begin
                            ms_count <= 10'h000;
                            sec_left <= sec_left - 16'h0001;
                        end
                        else
                        begin
                            ms_count <= ms_count + 10'h001;
                        end
                    end
                    else
                    begin
                        tick <= tick + 32'h00000001;
                    end
                    if (sec_left == 16'h0000)
                    begin
                        sl_state     <= SL_WAKE;
                        o_sleeping   <= 1'b0;
                        o_meas_start <= 1'b1;
                    end
                end
                default:
                begin
                    if (i_meas_valid)
                    begin
                        volume   <= i_clear_volume ? 48'h000000000000 :
                                    volume + (i_meas_flow * {16'h0000, sleep_len});
                        sl_state <= SL_AWAKE;
                    end
                end
            endcase
        end
    end

    // Reply sequencer: snapshot on accept keeps every word of one reply coherent.
    always @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state       <= ST_IDLE;
            head_idx    <= 2'h0;
            fc          <= 8'h00;
            slave       <= 8'h00;
            addr        <= 16'h0000;
            remain      <= 16'h0000;
            lo_byte     <= 1'b0;
            err_reply   <= 1'b0;
            err_code    <= 8'h00;
            crc         <= `FRR_CRC_INIT;
            o_req_ready <= 1'b0;
            o_tx_valid  <= 1'b0;
            o_tx_byte   <= 8'h00;
            o_tx_last   <= 1'b0;
            for (j = 0; j < 36; j = j + 1)
            begin
                snap[j] <= 16'h0000;
            end
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    o_req_ready <= 1'b1;
                    if (i_req_valid && o_req_ready)
                    begin
                        o_req_ready <= 1'b0;
                        slave       <= i_req_slave_addr;
                        fc          <= i_req_func;
                        addr        <= i_req_start;
                        remain      <= i_req_qty;
                        head_idx    <= 2'h0;
                        crc         <= `FRR_CRC_INIT;
                        lo_byte     <= 1'b0;
                        state       <= ST_HEAD;
                        err_reply   <= 1'b0;
                        if (i_req_func != `FRR_FC_READ_HOLD &&
                            i_req_func != `FRR_FC_READ_INPUT)
                        begin
                            err_reply <= 1'b1;
                            err_code  <= `FRR_FC_EXC_FUNC;
                        end
                        else if (i_req_qty == 16'h0000 || i_req_qty > `FRR_MAX_QTY)
                        begin
                            err_reply <= 1'b1;
                            err_code  <= `FRR_FC_EXC_ADDR;
                        end
                        for (j = 0; j < 36; j = j + 1)
                        begin
                            snap[j] <= 16'h0000;
                        end
                        snap[1]  <= velocity;
                        snap[2]  <= level;
                        snap[3]  <= air_gap;
                        snap[4]  <= small_flow;
                        snap[5]  <= volume[47:32];
                        snap[6]  <= volume[31:16];
                        snap[7]  <= volume[15:0];
                        snap[8]  <= vel_signal;
                        snap[9]  <= 16'h0000;
                        snap[10] <= direction;
                        snap[11] <= fault;
                        snap[12] <= tilt;
                        snap[13] <= supply;
                        snap[14] <= {FIRMWARE_VERSION[15:8], FIRMWARE_VERSION[7:0]};
                        snap[15] <= large_flow[31:16];
                        snap[16] <= large_flow[15:0];
                        snap[33] <= 16'h0000;
                        snap[34] <= tilt;
                        snap[35] <= supply;
                    end
                end
                ST_HEAD:
                begin
                    // The header byte stands until taken; the state moves on only after that.
                    if (!o_tx_valid)
                    begin
                        o_tx_valid <= 1'b1;
                        o_tx_byte  <= next_byte;
                        crc        <= next_crc;
                    end
                    else if (sending)
                    begin
                        o_tx_valid <= 1'b0;
                        head_idx   <= head_idx + 2'h1;
                        if (head_idx == 2'h2)
                        begin
                            state <= err_reply ? ST_CRC : ST_DATA;
                        end
                    end
                end
                ST_DATA:
                begin
                    if (!o_tx_valid)
                    begin
                        o_tx_valid <= 1'b1;
                        o_tx_byte  <= word_ok ? next_byte : 8'h00;
                        crc        <= word_ok ? next_crc : crc;
                        if (!word_ok && !lo_byte)
                        begin
                            err_reply <= 1'b1;
                            err_code  <= `FRR_FC_EXC_ADDR;
                        end
                    end
                    else if (sending)
                    begin
                        o_tx_valid <= 1'b0;
                        lo_byte    <= ~lo_byte;
                        if (lo_byte)
                        begin
                            addr   <= addr + 16'h0001;
                            remain <= remain - 16'h0001;
                            if (remain == 16'h0001)
                            begin
                                state <= ST_CRC;
                            end
                        end
                    end
                end
                ST_CRC:
                begin
                    if (!o_tx_valid)
                    begin
                        o_tx_valid <= 1'b1;
                        o_tx_byte  <= next_byte;
                        o_tx_last  <= lo_byte;
                    end
                    else if (sending)
                    begin
                        o_tx_valid <= 1'b0;
                        o_tx_last  <= 1'b0;
                        lo_byte    <= ~lo_byte;
                        if (lo_byte)
                        begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // frr_result_bank
`default_nettype wire

// ---- verification/frr_result_bank_checker.sv ----
// Concurrent checks on the result bank request, reply stream and sleep ports.
`timescale 1ns/1ps
`default_nettype none
module frr_result_bank_checker (
    input wire logic       i_sys_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_req_valid,
    input wire logic [7:0] i_req_slave_addr,
    input wire logic       i_sleep_request,
    input wire logic [15:0] i_sleep_seconds,
    input wire logic       i_tx_ready,
    input wire logic       o_req_ready,
    input wire logic       o_tx_valid,
    input wire logic [7:0] o_tx_byte,
    input wire logic       o_tx_last,
    input wire logic       o_meas_start,
    input wire logic       o_sleeping
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);
    sequence take_s;
        i_req_valid && o_req_ready;
    endsequence
    sequence head_s;
        !o_tx_valid ##1 (o_tx_valid && o_tx_byte == $past(i_req_slave_addr, 2));
    endsequence
    reply_head_a: assert property (take_s |=> head_s)
        else $error("reply head byte wrong or late");
    busy_refuse_a: assert property (take_s |=> !o_req_ready)
        else $error("request taken while busy");
    stream_busy_a: assert property (o_tx_valid |-> !o_req_ready)
        else $error("ready while reply streams");
    byte_hold_a: assert property (o_tx_valid && !i_tx_ready |=>
        o_tx_valid && $stable(o_tx_byte) && $stable(o_tx_last))
        else $error("reply byte not held");
    byte_gap_a: assert property (o_tx_valid && i_tx_ready |=> !o_tx_valid)
        else $error("no gap after accepted byte");
    frame_end_a: assert property (o_tx_valid && i_tx_ready && o_tx_last |->
        ##[1:4] o_req_ready)
        else $error("ready not back after frame");
    sleep_entry_a: assert property (i_sleep_request && i_sleep_seconds != 16'h0000 &&
        !o_sleeping |=> o_meas_start)
        else $error("no measurement before sleep");
    start_pulse_a: assert property (o_meas_start |=> !o_meas_start)
        else $error("measure start not a pulse");
    wake_start_a: assert property ($fell(o_sleeping) |-> ##[0:1] o_meas_start)
        else $error("no measurement on wake");
endmodule // frr_result_bank_checker

bind frr_result_bank frr_result_bank_checker chk (
    .i_sys_clk       (i_sys_clk),
    .i_sys_rst       (i_sys_rst),
    .i_req_valid     (i_req_valid),
    .i_req_slave_addr(i_req_slave_addr),
    .i_sleep_request (i_sleep_request),
    .i_sleep_seconds (i_sleep_seconds),
    .i_tx_ready      (i_tx_ready),
    .o_req_ready     (o_req_ready),
    .o_tx_valid      (o_tx_valid),
    .o_tx_byte       (o_tx_byte),
    .o_tx_last       (o_tx_last),
    .o_meas_start    (o_meas_start),
    .o_sleeping      (o_sleeping)
);
`default_nettype wire

// ---- verification/frr_reply_sink.sv ----
// Receiver of the polling master: takes reply bytes with random stalls.
`timescale 1ns/1ps
`default_nettype none
module frr_reply_sink (
    input  wire logic       i_sys_clk,
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_byte,
    input  wire logic       i_tx_last,
    output var  logic       o_tx_ready
);
    logic [7:0] got[$];
    int         last_pos = -1;
    initial o_tx_ready = 1'b0;
    always @(posedge i_sys_clk)
    begin
        if (o_tx_ready && i_tx_valid)
        begin
            if (i_tx_last)
                last_pos = got.size();
            got.push_back(i_tx_byte);
        end
        o_tx_ready <= #1 ($urandom_range(2) != 0);
    end
endmodule // frr_reply_sink
`default_nettype wire

// ---- verification/frr_result_bank_test.sv ----
// Self-checking bench for the result bank against a queue model.
`timescale 1ns/1ps
`default_nettype none
module frr_result_bank_test;
    logic        i_sys_clk, i_sys_rst, i_req_valid, i_meas_valid, i_meas_forward;
    logic        i_sleep_request, i_clear_volume, tx_ready, req_ready, tx_valid;
    logic        tx_last, meas_start, sleeping, settled;
    logic [7:0]  i_req_slave_addr, i_req_func, tx_byte;
    logic [15:0] i_req_start, i_req_qty, i_meas_velocity, i_meas_level, i_meas_air_gap;
    logic [15:0] i_meas_vel_signal, i_meas_fault, i_meas_tilt, i_meas_supply;
    logic [15:0] i_sleep_seconds, m_w[0:16];
    logic [31:0] i_meas_flow;
    logic [31:0] flows[3] = '{32'h0000ffff, 32'h00010000, 32'h12345678};
    logic [47:0] m_vol;
    int          mismatches, num_checks;

    frr_result_bank #(.SETTLE_CYC(32'd100), .MS_TICK_CYC(32'd2)) dut (
        .i_sys_clk        (i_sys_clk),
        .i_sys_rst        (i_sys_rst),
        .i_req_valid      (i_req_valid),
        .i_req_slave_addr (i_req_slave_addr),
        .i_req_func       (i_req_func),
        .i_req_start      (i_req_start),
        .i_req_qty        (i_req_qty),
        .i_meas_valid     (i_meas_valid),
        .i_meas_velocity  (i_meas_velocity),
        .i_meas_level     (i_meas_level),
        .i_meas_air_gap   (i_meas_air_gap),
        .i_meas_flow      (i_meas_flow),
        .i_meas_vel_signal(i_meas_vel_signal),
        .i_meas_forward   (i_meas_forward),
        .i_meas_fault     (i_meas_fault),
        .i_meas_tilt      (i_meas_tilt),
        .i_meas_supply    (i_meas_supply),
        .i_sleep_seconds  (i_sleep_seconds),
        .i_sleep_request  (i_sleep_request),
        .i_clear_volume   (i_clear_volume),
        .i_tx_ready       (tx_ready),
        .o_req_ready      (req_ready),
        .o_tx_valid       (tx_valid),
        .o_tx_byte        (tx_byte),
        .o_tx_last        (tx_last),
        .o_meas_start     (meas_start),
        .o_sleeping       (sleeping),
        .o_settled        (settled)
    );
    frr_reply_sink sink (
        .i_sys_clk (i_sys_clk),
        .i_tx_valid(tx_valid),
        .i_tx_byte (tx_byte),
        .i_tx_last (tx_last),
        .o_tx_ready(tx_ready)
    );

    always #4 i_sys_clk = ~i_sys_clk;

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] seen);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic [15:0] word(input logic [7:0] fc, input logic [15:0] a);
        if (fc == 8'h03)
            a = (a == 16'h0022 || a == 16'h0023) ? a - 16'h0016 : (a > 16'h000a ? 16'h0 : a);
        case (a)
            16'h0005: return m_vol[47:32];
            16'h0006: return m_vol[31:16];
            16'h0007: return m_vol[15:0];
            default:  return (a <= 16'h0010) ? m_w[a] : 16'h0000;
        endcase
    endfunction

    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i])
        begin
            c = c ^ {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction

    task automatic query(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] n);
        logic [7:0]  e[$];
        logic [7:0]  sl;
        logic [15:0] c;
        sl = 8'($urandom_range(247, 1));
        e = '{sl, fc};
        if (fc != 8'h03 && fc != 8'h04)
            e = '{sl, fc | 8'h80, 8'h01};
        else if (n == 16'h0 || n > 16'h007d)
            e = '{sl, fc | 8'h80, 8'h02};
        else
        begin
            e.push_back({n[6:0], 1'b0});
            for (int k = 0; k < n; k++)
            begin
                c = word(fc, a + 16'(k));
                e.push_back(c[15:8]);
                e.push_back(c[7:0]);
            end
        end
        c = crc16(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
        sink.got.delete();
        sink.last_pos = -1;
        {i_req_slave_addr, i_req_func, i_req_start, i_req_qty} = {sl, fc, a, n};
        i_req_valid = 1'b1;
        for (int k = 0; k < 50 && req_ready !== 1'b1; k++) @(posedge i_sys_clk) #1;
        @(posedge i_sys_clk) #1;
        i_req_valid = 1'b0;
        for (int k = 0; k < 500 && sink.got.size() < e.size(); k++) @(posedge i_sys_clk) #1;
        repeat (6) @(posedge i_sys_clk) #1;
        cmp("reply length", 16'(e.size()), 16'(sink.got.size()));
        cmp("last flag position", 16'(e.size() - 1), 16'(sink.last_pos));
        foreach (e[i])
            cmp("reply byte", {8'h00, e[i]}, {8'h00, sink.got[i]});
    endtask

    task automatic measure(input logic [31:0] f, input int wake_s);
        logic [127:0] r;
        r = {$urandom, $urandom, $urandom, $urandom};
        {i_meas_velocity, i_meas_level, i_meas_air_gap, i_meas_vel_signal} = r[63:0];
        {i_meas_fault, i_meas_tilt, i_meas_supply, i_meas_forward} = r[112:64];
        i_meas_flow = f;
        i_meas_valid = 1'b1;
        @(posedge i_sys_clk) #1;
        i_meas_valid = 1'b0;
        m_w[1] = i_meas_velocity;
        m_w[2] = i_meas_level;
        m_w[3] = i_meas_air_gap;
        m_w[4] = (f > 32'h0000ffff) ? 16'hffff : f[15:0];
        m_w[8] = i_meas_vel_signal;
        m_w[10] = {15'h0, i_meas_forward};
        m_w[11] = i_meas_fault;
        m_w[12] = i_meas_tilt;
        m_w[13] = i_meas_supply;
        m_w[15] = f[31:16];
        m_w[16] = f[15:0];
        m_vol = m_vol + 48'(f) * 48'(wake_s);
    endtask

    initial
    begin
        repeat (40000) @(posedge i_sys_clk);
        mismatches++;
        print_verdict();
    end

    initial
    begin
        {i_sys_clk, i_req_valid, i_meas_valid, i_sleep_request, i_clear_volume} = '0;
        {i_req_slave_addr, i_req_func, i_req_start, i_req_qty, i_meas_flow} = '0;
        {i_meas_velocity, i_meas_level, i_meas_air_gap, i_meas_vel_signal} = '0;
        {i_meas_fault, i_meas_tilt, i_meas_supply, i_meas_forward, i_sleep_seconds} = '0;
        foreach (m_w[i])
            m_w[i] = 16'h0000;
        m_w[14] = 16'h0100;
        m_vol = '0;
        i_sys_rst = 1'b1;
        void'($urandom(32'h4aec5e03));
        repeat (20) @(posedge i_sys_clk);
        #1 i_sys_rst = 1'b0;
        repeat (50) @(posedge i_sys_clk) #1;
        cmp("settled", 16'h0000, {15'h0, settled});
        repeat (60) @(posedge i_sys_clk) #1;
        cmp("settled", 16'h0001, {15'h0, settled});
        measure(32'($urandom_range(65534)), 0);
        query(8'h04, 16'h0001, 16'h0010);
        query(8'h03, 16'h0001, 16'h000a);
        query(8'h03, 16'h0021, 16'h0003);
        for (int i = 0; i < 6; i++)
            query(8'($urandom_range(4, 3)), 16'($urandom_range(10, 1)), 16'h1);
        $display("test maps done");
        foreach (flows[i])
        begin
            measure(flows[i], 0);
            query(8'h04, 16'h0004, 16'h0001);
            query(8'h04, 16'h000f, 16'h0002);
        end
        fork
            query(8'h04, 16'h0001, 16'h0010);
            measure(32'($urandom), 0);
        join
        $display("test flow done");
        query(8'h06, 16'h0001, 16'h0001);
        query(8'h04, 16'h0001, 16'h0000);
        query(8'h04, 16'h0001, 16'h007e);
        $display("test refusal done");
        i_sleep_seconds = 16'h0001;
        i_sleep_request = 1'b1;
        @(posedge i_sys_clk) #1;
        i_sleep_request = 1'b0;
        measure(32'($urandom_range(4000)), 0);
        @(posedge i_sys_clk) #1;
        cmp("sleeping", 16'h0001, {15'h0, sleeping});
        for (int k = 0; k < 3000 && sleeping; k++) @(posedge i_sys_clk) #1;
        cmp("sleeping", 16'h0000, {15'h0, sleeping});
        measure(32'($urandom_range(4000)), 1);
        query(8'h04, 16'h0001, 16'h0007);
        i_clear_volume = 1'b1;
        @(posedge i_sys_clk) #1;
        i_clear_volume = 1'b0;
        m_vol = '0;
        query(8'h03, 16'h0005, 16'h0003);
        $display("test sleep done");
        print_verdict();
    end
endmodule // frr_result_bank_test
`default_nettype wire
